// ===== logic/timer_pkg.sv
// Shared constants and types of the event and one-shot timer channel.
package timer_pkg;

  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FULL = 16'hffff;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    MODE_EVENT = 2'b00,
    MODE_TWO_PHASE = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_OFF = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    SRC_FALL = 2'b00,
    SRC_RISE = 2'b01,
    SRC_B_TIMER = 2'b10,
    SRC_PREV = 2'b11
  } ev_src_t;

  typedef enum logic [2:0] {
    TRIG_FALL = 3'b000,
    TRIG_RISE = 3'b001,
    TRIG_B_TIMER = 3'b010,
    TRIG_PREV = 3'b011,
    TRIG_NEXT = 3'b100,
    TRIG_SOFT = 3'b101
  } trig_t;

  typedef enum logic [1:0] {
    CLK_DIV1 = 2'b00,
    CLK_DIV8 = 2'b01,
    CLK_DIV32 = 2'b10,
    CLK_SUB32 = 2'b11
  } clk_sel_t;

  typedef enum logic [1:0] {
    PHASE_NONE = 2'b00,
    PHASE_NORMAL = 2'b01,
    PHASE_SELECT = 2'b10,
    PHASE_X4 = 2'b11
  } phase_kind_t;

  typedef enum logic {
    OS_IDLE = 1'b0,
    OS_RUN = 1'b1
  } os_state_t;

endpackage : timer_pkg

// ===== logic/sync_if.sv
// Synchronised pin level and its edge pulses.
`timescale 1ns/1ns
interface sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sync_if

// ===== logic/pin_sync.sv
// Three-stage pin synchroniser with filtered level and edge pulses.
`timescale 1ns/1ns
module pin_sync
  import timer_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Raw pin and its clean form.
  input wire logic pin,
  sync_if.src sync
);

  logic [2:0] stage;
  logic agree;

  // Only the second and third stages are compared; the first stays private.
  assign agree = stage[1] == stage[2];

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      stage <= SYNC_RESET;
    else
      stage <= {stage[1:0], pin};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sync.level <= 1'b0;
      sync.rise <= 1'b0;
      sync.fall <= 1'b0;
    end
    else
    begin
      sync.rise <= agree && stage[2] && !sync.level;
      sync.fall <= agree && !stage[2] && sync.level;
      if (agree)
        sync.level <= stage[2];
    end
  end

endmodule : pin_sync

// ===== logic/timer_channel.sv
// One timer channel: event counter, two-phase counter and one-shot timer.
//
// Function
// - Count start enables counting selected event edges
// - Free-run underflow wraps, no reload, raises request
// - Free-run overflow wraps, no reload, raises request
// - Direction change applies from next effective edge
// - Direction from software flag or phase pin
// - Two-phase counting starts with count start
// - Free-run times-four wraps without reload, raises request
// - Normal: input rise, phase high counts up
// - Normal: input fall, phase high counts down
// - Times-four counts all four edge pairings
// - Two-phase resolution set by channel kind, or by times-four select on the select kind
// - Software start begins down count, output high
// - Reaching zero: output low, reload, stop, request
// - Retrigger reloads at next count source pulse
// - Clearing count start: stop, reload, low, request
// - Zero timer value: no run, no request, no pulse
// - One-shot trigger: pin edge, overflows, software
// - One-shot clock from four strobes, output optional
// - Reload type reloads on wrap and continues
`timescale 1ns/1ns
module timer_channel
  import timer_pkg::*;
#(
  parameter phase_kind_t PHASE_KIND = PHASE_SELECT
)(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Pins.
  input wire logic channel_count_input_pin,
  input wire logic channel_output_phase_pin_in,
  output logic channel_output_phase_pin_out,
  output logic channel_output_phase_pin_oe,
  // Neighbour overflow strobes.
  input wire logic second_b_timer_overflow,
  input wire logic previous_channel_overflow,
  input wire logic next_channel_overflow,
  // Prescaled count source strobes.
  input wire logic internal_clock_div1,
  input wire logic internal_clock_div8,
  input wire logic internal_clock_div32,
  input wire logic subclock_div32,
  // Control.
  input wire mode_t mode,
  input wire logic count_start,
  input wire logic oneshot_start,
  input wire logic free_run,
  input wire ev_src_t event_source,
  input wire logic dir_from_pin,
  input wire logic up_flag,
  input wire logic times4_select,
  input wire trig_t trigger_select,
  input wire clk_sel_t clock_select,
  input wire logic pulse_out_enable,
  input wire logic timer_write,
  input wire logic [CNT_W-1:0] timer_value,
  input wire logic irq_clear,
  // Status.
  output logic [CNT_W-1:0] count_value,
  output logic irq_request,
  output logic overflow_out
);

  sync_if in_s ();
  sync_if ph_s ();

  logic [CNT_W-1:0] reload;
  logic start_d;
  os_state_t os_state;
  logic retrig_pending;

  logic ev_edge;
  logic ev_up;
  logic x4;
  logic tp_up;
  logic tp_down;
  logic step_up;
  logic step_down;
  logic os_tick;
  logic os_trig;
  logic armed;
  logic start_fall;
  logic os_start;
  logic os_done;
  logic os_stop;
  logic wrap;

  pin_sync u_in_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin(channel_count_input_pin),
    .sync(in_s.src)
  );

  pin_sync u_phase_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin(channel_output_phase_pin_in),
    .sync(ph_s.src)
  );

  always_comb
  begin
    unique case (event_source)
      SRC_FALL: ev_edge = in_s.fall;
      SRC_RISE: ev_edge = in_s.rise;
      SRC_B_TIMER: ev_edge = second_b_timer_overflow;
      SRC_PREV: ev_edge = previous_channel_overflow;
    endcase
    ev_up = dir_from_pin ? ph_s.level : up_flag;
    x4 = (PHASE_KIND == PHASE_X4) ||
      ((PHASE_KIND == PHASE_SELECT) && times4_select);
    tp_up = in_s.rise && ph_s.level;
    tp_down = in_s.fall && ph_s.level;
    if (x4)
    begin
      tp_up = (in_s.rise && ph_s.level) || (in_s.fall && !ph_s.level) ||
        (ph_s.rise && !in_s.level) || (ph_s.fall && in_s.level);
      tp_down = (in_s.fall && ph_s.level) || (in_s.rise && !ph_s.level) ||
        (ph_s.rise && in_s.level) || (ph_s.fall && !in_s.level);
    end
    if (PHASE_KIND == PHASE_NONE)
    begin
      tp_up = 1'b0;
      tp_down = 1'b0;
    end
  end

  always_comb
  begin
    step_up = 1'b0;
    step_down = 1'b0;
    if (count_start)
    begin
      if (mode == MODE_EVENT)
      begin
        step_up = ev_edge && ev_up;
        step_down = ev_edge && !ev_up;
      end
      else if (mode == MODE_TWO_PHASE)
      begin
        step_up = tp_up;
        step_down = tp_down;
      end
    end
  end

  always_comb
  begin
    unique case (clock_select)
      CLK_DIV1: os_tick = internal_clock_div1;
      CLK_DIV8: os_tick = internal_clock_div8;
      CLK_DIV32: os_tick = internal_clock_div32;
      CLK_SUB32: os_tick = subclock_div32;
    endcase
    unique case (trigger_select)
      TRIG_FALL: os_trig = in_s.fall;
      TRIG_RISE: os_trig = in_s.rise;
      TRIG_B_TIMER: os_trig = second_b_timer_overflow;
      TRIG_PREV: os_trig = previous_channel_overflow;
      TRIG_NEXT: os_trig = next_channel_overflow;
      TRIG_SOFT: os_trig = oneshot_start;
      default: os_trig = 1'b0;
    endcase
  end

  assign armed = (mode == MODE_ONESHOT) && count_start && (reload != CNT_ZERO);
  assign start_fall = start_d && !count_start;
  assign os_start = armed && os_trig && (os_state == OS_IDLE);
  assign os_done = (os_state == OS_RUN) && os_tick && !retrig_pending &&
    (count_value == CNT_ONE) && !start_fall;
  assign os_stop = (mode == MODE_ONESHOT) && start_fall &&
    (reload != CNT_ZERO);
  assign wrap = (step_up && (count_value == CNT_FULL)) ||
    (step_down && (count_value == CNT_ZERO));

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      start_d <= 1'b0;
    else
      start_d <= count_start;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      reload <= RELOAD_RESET;
    else if (timer_write)
      reload <= timer_value;
  end

  // A write while counting only updates the reload register, so a running
  // count is never disturbed mid-period.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      count_value <= CNT_RESET;
    else if (timer_write && !count_start)
      count_value <= timer_value;
    else if (mode == MODE_ONESHOT)
    begin
      if (start_fall || os_done || os_start)
        count_value <= reload;
      else if (os_state == OS_RUN && os_tick)
        count_value <= retrig_pending ? reload : count_value - CNT_ONE;
    end
    else if (wrap && !free_run)
      count_value <= reload;
    else if (step_up)
      count_value <= count_value + CNT_ONE;
    else if (step_down)
      count_value <= count_value - CNT_ONE;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      os_state <= OS_IDLE;
    else
    begin
      unique case (os_state)
        OS_IDLE:
          if (os_start)
            os_state <= OS_RUN;
        OS_RUN:
          if (os_done || start_fall || mode != MODE_ONESHOT)
            os_state <= OS_IDLE;
      endcase
    end
  end

  // A trigger in the same cycle as a tick waits for the following tick.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      retrig_pending <= 1'b0;
    else if (os_state != OS_RUN || start_fall)
      retrig_pending <= 1'b0;
    else if (armed && os_trig)
      retrig_pending <= 1'b1;
    else if (os_tick)
      retrig_pending <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      channel_output_phase_pin_out <= 1'b0;
      channel_output_phase_pin_oe <= 1'b0;
    end
    else
    begin
      channel_output_phase_pin_oe <= (mode == MODE_ONESHOT) &&
        pulse_out_enable;
      if (os_start && pulse_out_enable)
        channel_output_phase_pin_out <= 1'b1;
      else if (os_done || start_fall || mode != MODE_ONESHOT)
        channel_output_phase_pin_out <= 1'b0;
    end
  end

  // Hardware setting wins over a clear in the same cycle.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      irq_request <= 1'b0;
    else if (wrap || os_done || os_stop)
      irq_request <= 1'b1;
    else if (irq_clear)
      irq_request <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      overflow_out <= 1'b0;
    else
      overflow_out <= wrap || os_done;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_event_count_up:
    assert property (mode == MODE_EVENT && step_up && !timer_write &&
      count_value != CNT_FULL |=> count_value == $past(count_value) + CNT_ONE)
    else $error("event up count missed");

  a_free_underflow:
    assert property (step_down && free_run && count_value == CNT_ZERO
      |=> count_value == CNT_FULL && irq_request && overflow_out)
    else $error("free-run underflow wrong");

  a_free_overflow:
    assert property (step_up && free_run && count_value == CNT_FULL
      |=> count_value == CNT_ZERO && irq_request)
    else $error("free-run overflow wrong");

  a_pin_direction:
    assert property (mode == MODE_EVENT && count_start && ev_edge &&
      dir_from_pin && !ph_s.level && count_value != CNT_ZERO
      |=> count_value == $past(count_value) - CNT_ONE)
    else $error("pin direction not followed");

  a_normal_phase:
    assert property (mode == MODE_TWO_PHASE && count_start && !x4 &&
      PHASE_KIND != PHASE_NONE && in_s.rise && ph_s.level |-> step_up)
    else $error("normal two-phase up missed");

  a_x4_down:
    assert property (mode == MODE_TWO_PHASE && count_start && x4 &&
      ph_s.fall && !in_s.level |-> step_down && !step_up)
    else $error("times-four down missed");

  a_oneshot_start:
    assert property (os_start && pulse_out_enable
      |=> channel_output_phase_pin_out && os_state == OS_RUN)
    else $error("one-shot start failed");

  a_oneshot_end:
    assert property (os_done |=> !channel_output_phase_pin_out &&
      os_state == OS_IDLE && irq_request && count_value == $past(reload))
    else $error("one-shot end wrong");

  a_stop_reload:
    assert property (os_state == OS_RUN && start_fall && !timer_write
      |=> os_state == OS_IDLE && count_value == $past(reload) &&
      !channel_output_phase_pin_out)
    else $error("stop did not reload");

  a_zero_idle:
    assert property (reload == CNT_ZERO && os_state == OS_IDLE
      |=> os_state == OS_IDLE)
    else $error("zero value started a one-shot");

  a_reload_wrap:
    assert property (wrap && !free_run && !timer_write
      |=> count_value == $past(reload) && irq_request)
    else $error("reload type did not reload");

  c_underflow: cover property (step_down && count_value == CNT_ZERO);
  c_x4_up: cover property (x4 && step_up && mode == MODE_TWO_PHASE);
  c_oneshot_done: cover property (os_done);
  c_retrigger: cover property (retrig_pending && os_tick);

endmodule : timer_channel

// ===== test/quad_source.sv
// Encoder and event pin source standing in for the external signals.
`timescale 1ns/1ns
module quad_source
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Step command.
  input wire logic step,
  input wire logic up,
  // Encoder pins.
  output logic pin_a,
  output logic pin_b
);
  logic [1:0] pos;

  // Each step moves one edge, so the two pins never change together.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pos <= 2'h0;
    else if (step)
      pos <= up ? pos + 2'h1 : pos - 2'h1;
  end

  // Counting up walks (a, b) through 01, 11, 10, 00.
  always_comb
  begin
    case (pos)
      2'h0: {pin_a, pin_b} = 2'b01;
      2'h1: {pin_a, pin_b} = 2'b11;
      2'h2: {pin_a, pin_b} = 2'b10;
      default: {pin_a, pin_b} = 2'b00;
    endcase
  end
endmodule : quad_source

// ===== test/timer_event_oneshot_counter_tb.sv
// Self-checking bench for the event, two-phase and one-shot channel.
`timescale 1ns/1ns
module timer_event_oneshot_counter_tb
  import timer_pkg::*;
;
  logic clock, rst_b, qstep, qup, count_start, free_run, dir_from_pin;
  logic up_flag, times4_select, pulse_out_enable;
  mode_t mode;
  ev_src_t event_source;
  trig_t trigger_select;
  clk_sel_t clock_select;
  logic [15:0] timer_value;
  logic [9:0] pul;
  logic qa, qb, pout, poe, ovf, irq, phase;
  logic [15:0] cnt;
  int mismatches, num_checks;

  // The pin level is the channel's own drive while it owns the pin.
  assign phase = poe ? pout : qb;

  quad_source quad_source_i (.clock, .rst_b, .step(qstep), .up(qup),
    .pin_a(qa), .pin_b(qb));

  timer_channel timer_channel_i (.clock, .rst_b,
    .channel_count_input_pin(qa), .channel_output_phase_pin_in(phase),
    .channel_output_phase_pin_out(pout), .channel_output_phase_pin_oe(poe),
    .second_b_timer_overflow(pul[4]), .previous_channel_overflow(pul[5]),
    .next_channel_overflow(pul[6]), .internal_clock_div1(pul[0]),
    .internal_clock_div8(pul[1]), .internal_clock_div32(pul[2]),
    .subclock_div32(pul[3]), .mode, .count_start,
    .oneshot_start(pul[7]), .free_run, .event_source, .dir_from_pin,
    .up_flag, .times4_select, .trigger_select, .clock_select,
    .pulse_out_enable, .timer_write(pul[9]), .timer_value,
    .irq_clear(pul[8]), .count_value(cnt), .irq_request(irq),
    .overflow_out(ovf));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task step;
    @(posedge clock);
    #1;
  endtask : step

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // One-cycle strobe, then one more edge so the answer has landed.
  task pls(input logic [9:0] v);
    pul = v;
    step;
    pul = 10'h000;
    step;
  endtask : pls

  // Like pls, but the channel's overflow output is judged while the strobe stands.
  task pls_ovf(input logic [9:0] v, input logic exp);
    pul = v;
    step;
    chk({15'h0, ovf}, {15'h0, exp});
    pul = 10'h000;
    step;
    chk({15'h0, ovf}, 16'h0000);
  endtask : pls_ovf

  // Steps are spaced well beyond the pin synchroniser depth.
  task quad(input logic up, input int n);
    repeat (n)
    begin
      qup = up;
      qstep = 1'b1;
      step;
      qstep = 1'b0;
      repeat (9) step;
    end
  endtask : quad

  task wait_for(input logic [15:0] exp);
    int k;
    k = 0;
    while (cnt !== exp && k < 24)
    begin
      step;
      k++;
    end
    chk(cnt, exp);
    if (cnt !== exp)
      stop_test;
  endtask : wait_for

  task ev_freerun;
    pls_ovf(10'h010, 1'b0);
    chk(cnt, 16'h0000);
    count_start = 1'b1;
    pls_ovf(10'h010, 1'b1);
    wait_for(16'hffff);
    chk({15'h0, irq}, 16'h0001);
    pls(10'h100);
    up_flag = 1'b1;
    pls_ovf(10'h010, 1'b1);
    wait_for(16'h0000);
    chk({15'h0, irq}, 16'h0001);
  endtask : ev_freerun

  task ev_sources;
    event_source = SRC_PREV;
    pls(10'h020);
    wait_for(16'h0001);
    event_source = SRC_RISE;
    dir_from_pin = 1'b1;
    up_flag = 1'b0;
    quad(1'b1, 1);
    wait_for(16'h0002);
    event_source = SRC_FALL;
    quad(1'b1, 1);
    chk(cnt, 16'h0002);
    quad(1'b1, 1);
    wait_for(16'h0001);
  endtask : ev_sources

  task reload_type;
    count_start = 1'b0;
    dir_from_pin = 1'b0;
    free_run = 1'b0;
    timer_value = 16'h0001;
    pls(10'h200);
    count_start = 1'b1;
    event_source = SRC_B_TIMER;
    pls(10'h010);
    wait_for(16'h0000);
    pls(10'h100);
    pls(10'h010);
    wait_for(16'h0001);
    chk({15'h0, irq}, 16'h0001);
  endtask : reload_type

  task two_phase;
    count_start = 1'b0;
    mode = MODE_TWO_PHASE;
    free_run = 1'b1;
    timer_value = 16'h0010;
    pls(10'h200);
    count_start = 1'b1;
    quad(1'b1, 4);
    wait_for(16'h0011);
    quad(1'b0, 4);
    wait_for(16'h0010);
    times4_select = 1'b1;
    quad(1'b1, 4);
    wait_for(16'h0014);
    quad(1'b0, 4);
    wait_for(16'h0010);
    count_start = 1'b0;
    timer_value = 16'h0000;
    pls(10'h200);
    count_start = 1'b1;
    pls(10'h100);
    quad(1'b0, 1);
    wait_for(16'hffff);
    chk({15'h0, irq}, 16'h0001);
  endtask : two_phase

  task one_shot;
    count_start = 1'b0;
    mode = MODE_ONESHOT;
    pulse_out_enable = 1'b1;
    timer_value = 16'h0003;
    pls(10'h200);
    count_start = 1'b1;
    pls(10'h100);
    pls(10'h080);
    chk({15'h0, pout}, 16'h0001);
    chk(cnt, 16'h0003);
    pls(10'h001);
    pls(10'h080);
    pls(10'h001);
    chk(cnt, 16'h0003);
    pls(10'h001);
    pls(10'h001);
    chk({15'h0, irq}, 16'h0000);
    pls_ovf(10'h001, 1'b1);
    chk({pout, irq, cnt[13:0]}, 16'h4003);
    pls(10'h100);
    pls(10'h080);
    pls(10'h001);
    count_start = 1'b0;
    step;
    step;
    chk({pout, irq, cnt[13:0]}, 16'h4003);
    count_start = 1'b1;
    clock_select = CLK_DIV8;
    pls(10'h080);
    pls(10'h001);
    chk(cnt, 16'h0003);
    pls(10'h002);
    chk({poe, cnt[14:0]}, 16'h8002);
    count_start = 1'b0;
    step;
    timer_value = 16'h0000;
    pls(10'h200);
    count_start = 1'b1;
    pls(10'h100);
    pls(10'h080);
    pls(10'h002);
    chk({pout, irq, cnt[13:0]}, 16'h0000);
  endtask : one_shot

  task triggers;
    trig_t tl [3];
    tl = '{TRIG_B_TIMER, TRIG_PREV, TRIG_NEXT};
    count_start = 1'b0;
    timer_value = 16'h0002;
    pls(10'h200);
    for (int i = 0; i < 3; i++)
    begin
      trigger_select = tl[i];
      count_start = 1'b1;
      pls(10'h010 << i);
      chk({15'h0, pout}, 16'h0001);
      count_start = 1'b0;
      step;
      step;
    end
  endtask : triggers

  // Pin-edge triggers with the two slow count sources, then the off mode.
  task pin_triggers;
    trigger_select = TRIG_FALL;
    clock_select = CLK_DIV32;
    count_start = 1'b1;
    quad(1'b0, 2);
    chk({15'h0, pout}, 16'h0001);
    pls(10'h004);
    chk(cnt, 16'h0001);
    count_start = 1'b0;
    step;
    step;
    trigger_select = TRIG_RISE;
    clock_select = CLK_SUB32;
    count_start = 1'b1;
    quad(1'b1, 2);
    chk({15'h0, pout}, 16'h0001);
    pls(10'h008);
    pls_ovf(10'h008, 1'b1);
    chk({pout, cnt[14:0]}, 16'h0002);
    mode = MODE_OFF;
    pls(10'h010);
    chk({poe, cnt[14:0]}, 16'h0002);
  endtask : pin_triggers

  initial
  begin
    {rst_b, qstep, qup, count_start, dir_from_pin, up_flag} = 6'h00;
    {times4_select, pulse_out_enable, free_run} = 3'h1;
    {mode, event_source, trigger_select} = {MODE_EVENT, SRC_B_TIMER, TRIG_SOFT};
    clock_select = CLK_DIV1;
    timer_value = 16'h0000;
    pul = 10'h000;
    mismatches = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (4) step;
    ev_freerun;
    ev_sources;
    reload_type;
    two_phase;
    one_shot;
    triggers;
    pin_triggers;
    stop_test;
  end
endmodule : timer_event_oneshot_counter_tb
